// >>> design/scs_clock_select.sv
// System clock selector: source choice, output prescaler, flash wait-state setting
//
// Functional notes
// R1: Source select 11 passes the direct clock input straight to the system clock, same frequency and duty.
// R2: Prescaler from the crystal input with factor one gives the same result as direct drive.
// R3: Source select 10 with the bypass bit set chooses prescaler mode from the crystal or the internal oscillator.
// R4: In prescaler mode the system clock is the oscillator divided by the divider setting plus one.
// R5: With factor one the system clock follows the oscillator level and thus its duty cycle.
// R6: The largest factor is 1024, giving the oscillator divided by 1024.
// R7: Software picks the flash wait states for the clock rate, four always safe, three to 17 MHz, two to 13, one to 8.
// R8: Software never selects zero flash wait states.
// R9: Flash wait states delay only non-sequential accesses; sequential ones are served from prefetch.
// R10: Source select 10 with the bypass bit clear enables the loop and takes the clock from its output.
// R11: Source select 00 takes the system clock from the wakeup oscillator.
// R12: The divider setting is ten bits wide, values 0 to 1023 giving factors 1 to 1024.
`timescale 1ns/100ps
`default_nettype none
`include "scs_consts.svh"

module scs_clock_select #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [`SCS_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [`SCS_DATA_W-1:0]      reg_rdata,
  // Clock sources and result
  input  wire scs_pkg::scs_src_t      src,
  output logic                        sys_clk_out,
  output logic                        loop_enable,
  // Flash access timing
  input  wire scs_pkg::scs_acc_t      flash_acc,
  output logic [2:0]                  flash_wait_states,
  output logic                        flash_acc_done
);

  // Wider addresses would alias onto the four registers through the 4-bit decode
  if ((ADDR_W < 2) || (ADDR_W > 4)) begin : g_addr_check
    $error("ADDR_W does not fit the register map");
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [1:0]  clock_source_select_r;
  logic [9:0]  output_divider_setting_r;
  logic        vco_bypass_r;
  logic        internal_osc_sel_r;
  logic [2:0]  flash_ws_r;

  wire [3:0] addr_w     = 4'(reg_addr);
  wire hit_sys_w        = (addr_w == `SCS_ADDR_SYSCFG);
  wire hit_loop_w       = (addr_w == `SCS_ADDR_LOOPCFG);
  wire hit_ws_w         = (addr_w == `SCS_ADDR_FLASHWS);
  wire hit_stat_w       = (addr_w == `SCS_ADDR_STATUS);
  wire [2:0] ws_wdata_w = reg_wdata[`SCS_WS_MSB:0];
  // A zero wait-state write would break flash reads, so it is dropped
  wire ws_ok_w          = (ws_wdata_w != `SCS_WS_FORBIDDEN); // R8

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clock_source_select_r    <= `SCS_SEL_RST;
      output_divider_setting_r <= `SCS_DIV_RST;
      vco_bypass_r             <= 1'b1;
      internal_osc_sel_r       <= 1'b0;
      flash_ws_r               <= `SCS_WS_RST; // R7
    end else if (reg_wr) begin
      if (hit_sys_w) begin
        clock_source_select_r <= reg_wdata[`SCS_SEL_MSB:0];
      end else if (hit_loop_w) begin
        output_divider_setting_r <= reg_wdata[`SCS_DIV_MSB:0]; // R12
        vco_bypass_r             <= reg_wdata[`SCS_BYPASS_BIT];
        internal_osc_sel_r       <= reg_wdata[`SCS_INTOSC_BIT];
      end else if (hit_ws_w && ws_ok_w) begin
        flash_ws_r <= ws_wdata_w; // R8
      end
    end
  end

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  wire sel_direct_w = (clock_source_select_r == `SCS_SEL_DIRECT);
  wire sel_loop_w   = (clock_source_select_r == `SCS_SEL_LOOP);
  // Reserved select code 01 falls back to the wakeup source, the safest clock
  wire scs_pkg::scs_mode_t mode_w =
    sel_direct_w                ? scs_pkg::SCS_MODE_DIRECT :   // R1
    (sel_loop_w && vco_bypass_r) ? scs_pkg::SCS_MODE_PRESCALE : // R3
    sel_loop_w                  ? scs_pkg::SCS_MODE_LOOP :      // R10
                                  scs_pkg::SCS_MODE_WAKEUP;     // R11

  // ********************************************************************
  // Output prescaler
  // ********************************************************************
  logic       osc_prev_r;
  logic [9:0] div_cnt_r;

  wire osc_w       = internal_osc_sel_r ? src.internal_osc : src.crystal_input; // R3
  wire osc_rise_w  = osc_w && !osc_prev_r;
  wire div_one_w   = (output_divider_setting_r == `SCS_DIV_RST);
  // Wrap on >= so that shrinking the setting never strands the counter
  wire cnt_wrap_w  = (div_cnt_r >= output_divider_setting_r); // R4 R6
  wire [9:0] div_cnt_nxt = !osc_rise_w ? div_cnt_r :
                           cnt_wrap_w  ? 10'h000 : div_cnt_r + 10'h001;
  // High for the first half of the factor, rounded up for odd factors
  wire [10:0] half_w = ({1'b0, output_divider_setting_r} + 11'h002) >> 1;
  wire div_clk_w     = ({1'b0, div_cnt_nxt} < half_w); // R4

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_prev_r <= 1'b0;
      div_cnt_r  <= 10'h000;
    end else begin
      osc_prev_r <= osc_w;
      div_cnt_r  <= div_cnt_nxt;
    end
  end

  // ********************************************************************
  // Clock selection
  // ********************************************************************
  // Factor one bypasses the counter so the oscillator duty survives
  wire presc_clk_w = div_one_w ? osc_w : div_clk_w; // R2 R5
  wire clk_nxt_w =
    (mode_w == scs_pkg::SCS_MODE_DIRECT)   ? src.direct_clock_input : // R1
    (mode_w == scs_pkg::SCS_MODE_PRESCALE) ? presc_clk_w :
    (mode_w == scs_pkg::SCS_MODE_LOOP)     ? src.loop_output :        // R10
                                             src.wakeup_osc;          // R11
  wire loop_en_nxt_w = (mode_w == scs_pkg::SCS_MODE_LOOP); // R10

  // ********************************************************************
  // Read data
  // ********************************************************************
  wire [`SCS_DATA_W-1:0] rd_sys_w  = `SCS_DATA_W'(clock_source_select_r);
  wire [`SCS_DATA_W-1:0] rd_loop_w = `SCS_DATA_W'({internal_osc_sel_r, vco_bypass_r, output_divider_setting_r});
  wire [`SCS_DATA_W-1:0] rd_ws_w   = `SCS_DATA_W'(flash_ws_r);
  wire [`SCS_DATA_W-1:0] rd_stat_w = `SCS_DATA_W'({loop_enable, mode_w});
  wire [`SCS_DATA_W-1:0] rd_w =
    hit_sys_w  ? rd_sys_w  :
    hit_loop_w ? rd_loop_w :
    hit_ws_w   ? rd_ws_w   :
    hit_stat_w ? rd_stat_w : '0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_clk_out       <= 1'b0;
      loop_enable       <= 1'b0;
      reg_rdata         <= '0;
      flash_wait_states <= `SCS_WS_RST;
    end else begin
      sys_clk_out       <= clk_nxt_w;
      loop_enable       <= loop_en_nxt_w;
      reg_rdata         <= reg_rd ? rd_w : '0;
      flash_wait_states <= flash_ws_r; // R7
    end
  end

  // ********************************************************************
  // Flash access timing
  // ********************************************************************
  scs_flash_wait u_flash_wait (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .wait_states (flash_ws_r),
    .acc         (flash_acc),
    .acc_done    (flash_acc_done)
  );

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Every clock path is registered, so each clock routing check looks one cycle after the decode
  chk_direct_follow: assert property (mode_w == scs_pkg::SCS_MODE_DIRECT |=> // R1
    sys_clk_out == $past(src.direct_clock_input))
    else $error("direct drive clock does not follow its input");
  chk_presc_one: assert property (mode_w == scs_pkg::SCS_MODE_PRESCALE && div_one_w |=> // R2 R5
    sys_clk_out == $past(osc_w))
    else $error("factor one prescaler does not follow oscillator");
  chk_presc_divided: assert property (mode_w == scs_pkg::SCS_MODE_PRESCALE && !div_one_w |=> // R4
    sys_clk_out == $past(div_clk_w))
    else $error("divided prescaler clock not routed");
  chk_loop_enable: assert property (mode_w == scs_pkg::SCS_MODE_LOOP [*2] |-> // R10
    loop_enable && sys_clk_out == $past(src.loop_output))
    else $error("loop mode not enabled or not routed");
  chk_wakeup_follow: assert property (mode_w == scs_pkg::SCS_MODE_WAKEUP |=> // R11
    !loop_enable && sys_clk_out == $past(src.wakeup_osc))
    else $error("wakeup clock not routed");
  chk_loop_off: assert property (mode_w != scs_pkg::SCS_MODE_LOOP |=> !loop_enable) // R10
    else $error("loop enabled outside loop mode");
  chk_div_range: assert property (osc_rise_w |=> div_cnt_r <= $past(output_divider_setting_r)) // R4 R12
    else $error("prescaler count beyond divider setting");
  chk_div_wrap_zero: assert property (osc_rise_w && cnt_wrap_w |=> div_cnt_r == 10'h000) // R4
    else $error("prescaler count does not restart after its last step");
  chk_div_max_wrap: assert property (div_cnt_r == `SCS_DIV_MAX && osc_rise_w |=> div_cnt_r == 10'h000) // R6
    else $error("prescaler count does not wrap at factor 1024");
  chk_ws_zero_drop: assert property (reg_wr && hit_ws_w && !ws_ok_w |=> // R8
    ##1 flash_wait_states == $past(flash_ws_r, 2))
    else $error("zero wait states were accepted");
  chk_read_status: assert property (reg_rd && hit_stat_w |=>
    reg_rdata == `SCS_DATA_W'({$past(loop_enable), $past(mode_w)}))
    else $error("status read returned wrong data");
  // Read data drops back to zero so a stale word is never taken twice
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data present without a read");
  chk_ws_reset_safe: assert property ($rose(rst_n) |-> flash_wait_states == `SCS_WS_RST) // R7
    else $error("wait states not four after reset");

  cov_direct_mode: cover property (mode_w == scs_pkg::SCS_MODE_DIRECT ##1 $rose(sys_clk_out));
  cov_presc_divide: cover property (mode_w == scs_pkg::SCS_MODE_PRESCALE && !div_one_w && osc_rise_w && cnt_wrap_w);
  cov_loop_mode: cover property ($rose(loop_enable));
  cov_wakeup_mode: cover property (mode_w == scs_pkg::SCS_MODE_WAKEUP ##1 $rose(sys_clk_out));

endmodule
`default_nettype wire

// >>> design/scs_consts.svh
// Register map, field positions, codes and reset values of the system clock selector
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define SCS_ADDR_SYSCFG   4'h0
`define SCS_ADDR_LOOPCFG  4'h1
`define SCS_ADDR_FLASHWS  4'h2
`define SCS_ADDR_STATUS   4'h3

// ********************************************************************
// Field layout
// ********************************************************************
`define SCS_DATA_W        16
`define SCS_SEL_MSB       1
`define SCS_DIV_MSB       9
`define SCS_BYPASS_BIT    10
`define SCS_INTOSC_BIT    11
`define SCS_WS_MSB        2
`define SCS_STAT_PLL_BIT  3

// ********************************************************************
// Codes and reset values
// ********************************************************************
`define SCS_SEL_WAKEUP    2'h0
`define SCS_SEL_LOOP      2'h2
`define SCS_SEL_DIRECT    2'h3
`define SCS_SEL_RST       2'h2
`define SCS_DIV_RST       10'h000
`define SCS_DIV_MAX       10'h3ff
`define SCS_WS_FORBIDDEN  3'h0
`define SCS_WS_RST        3'h4
`define SCS_FREQ_WS3_MHZ  17
`define SCS_FREQ_WS2_MHZ  13
`define SCS_FREQ_WS1_MHZ  8

`endif

// >>> design/scs_flash_wait.sv
// Flash access timing: wait states for non-sequential accesses only
`timescale 1ns/100ps
`default_nettype none
`include "scs_consts.svh"

module scs_flash_wait (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Setting and access
  input  wire logic [2:0]        wait_states,
  input  wire scs_pkg::scs_acc_t acc,
  output logic                   acc_done
);

  typedef enum logic {SCS_FW_IDLE, SCS_FW_WAIT} scs_fw_state_t;

  scs_fw_state_t state_r;
  scs_fw_state_t state_nxt;
  logic [2:0]    cnt_r;
  logic [2:0]    cnt_nxt;
  logic          done_nxt;

  // Sequential fetches come from the prefetch buffer and skip the wait
  wire take_w   = (state_r == SCS_FW_IDLE) && acc.req;
  wire fast_w   = acc.seq || (wait_states == `SCS_WS_FORBIDDEN); // R9
  wire last_w   = (cnt_r == 3'h1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    case (state_r)
      SCS_FW_IDLE: begin
        if (take_w && fast_w) begin
          done_nxt = 1'b1;
        end else if (take_w) begin
          state_nxt = SCS_FW_WAIT;
          cnt_nxt   = wait_states;
        end
      end
      SCS_FW_WAIT: begin
        cnt_nxt = cnt_r - 3'h1;
        if (last_w) begin
          state_nxt = SCS_FW_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default: state_nxt = SCS_FW_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r  <= SCS_FW_IDLE;
      cnt_r    <= 3'h0;
      acc_done <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      acc_done <= done_nxt;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_seq_no_wait: assert property (take_w && acc.seq |=> acc_done) // R9
    else $error("sequential access was delayed");
  chk_nonseq_four_ws: assert property (take_w && !acc.seq && wait_states == `SCS_WS_RST |=> // R9
    !acc_done [*4] ##1 acc_done)
    else $error("non-sequential access did not take four wait states");
  cov_nonseq_access: cover property (take_w && !acc.seq ##[1:8] acc_done);

endmodule
`default_nettype wire

// >>> design/scs_pkg.sv
// Types shared by the system clock selector files
`default_nettype none
package scs_pkg;

  // Sampled levels of every candidate clock source
  typedef struct packed {
    logic direct_clock_input;
    logic crystal_input;
    logic internal_osc;
    logic loop_output;
    logic wakeup_osc;
  } scs_src_t;

  // Clock generation method currently in force
  typedef enum logic [2:0] {
    SCS_MODE_WAKEUP,
    SCS_MODE_PRESCALE,
    SCS_MODE_LOOP,
    SCS_MODE_DIRECT
  } scs_mode_t;

  // Flash access request from the fetch unit
  typedef struct packed {
    logic req;
    logic seq;
  } scs_acc_t;

endpackage
`default_nettype wire

// >>> test/scs_clock_select_tb.sv
// Self-checking bench for the system clock selector
`timescale 1ns/100ps
`default_nettype none
`include "scs_consts.svh"

module scs_clock_select_tb;
  logic              clk_sys   = 1'b0;
  logic              rst_n     = 1'b0;
  logic [3:0]        reg_addr  = 4'h0;
  logic [15:0]       reg_wdata = 16'h0000;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [15:0]       reg_rdata;
  scs_pkg::scs_src_t src;
  logic              sys_clk_out;
  logic              loop_enable;
  scs_pkg::scs_acc_t flash_acc = 2'b00;
  logic [2:0]        flash_wait_states;
  logic              flash_acc_done;
  int                miscompares = 0;
  int                n_compared  = 0;

  always #25 clk_sys = ~clk_sys;

  scs_clock_select u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src(src), .sys_clk_out(sys_clk_out),
    .loop_enable(loop_enable), .flash_acc(flash_acc), .flash_wait_states(flash_wait_states),
    .flash_acc_done(flash_acc_done));

  scs_src_model u_src (.clk_sys(clk_sys), .src(src));

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    cmp_val(reg_rdata, exp);
  endtask

  // Output is the chosen source one cycle late
  task automatic follow(input int idx);
    logic last;
    @(negedge clk_sys);
    last = src[idx];
    repeat (12) begin
      @(negedge clk_sys);
      cmp_val(16'(sys_clk_out), 16'(last));
      last = src[idx];
    end
  endtask

  // Bounded wait so a stuck output ends as a mismatch, not a hang
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sys_clk_out !== v && n < 5000);
  endtask

  task automatic access(input logic sq, input int exp);
    int n;
    @(posedge clk_sys);
    flash_acc <= {1'b1, sq};
    @(posedge clk_sys);
    flash_acc <= 2'b00;
    n = 1;
    @(negedge clk_sys);
    while (flash_acc_done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_val(16'(n), 16'(exp));
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset;
    reg_check(`SCS_ADDR_SYSCFG, 16'h0002);
    reg_check(`SCS_ADDR_LOOPCFG, 16'h0400);
    reg_check(`SCS_ADDR_FLASHWS, 16'h0004);
    reg_check(`SCS_ADDR_STATUS, 16'h0001);
    cmp_val(16'(flash_wait_states), 16'h0004);
    cmp_val(16'(loop_enable), 16'h0000);
  endtask

  // Wakeup, reserved code, direct, loop, prescaler from crystal and internal
  task automatic t_modes;
    logic [1:0]  sel [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2};
    logic [15:0] lc  [6] = '{16'h0400, 16'h0400, 16'h0400, 16'h0000, 16'h0400, 16'h0c00};
    int          idx [6] = '{0, 0, 4, 1, 3, 2};
    logic [15:0] st  [6] = '{16'h0000, 16'h0000, 16'h0003, 16'h000a, 16'h0001, 16'h0001};
    for (int i = 0; i < 6; i++) begin
      reg_write(`SCS_ADDR_LOOPCFG, lc[i]);
      reg_write(`SCS_ADDR_SYSCFG, 16'(sel[i]));
      follow(idx[i]);
      cmp_val(16'(loop_enable), 16'(sel[i] == 2'h2 && lc[i][10] == 1'b0));
      if (i != 1) begin
        reg_check(`SCS_ADDR_STATUS, st[i]);
      end
    end
  endtask

  // Crystal rises every 2 cycles, so one output period is 2*K cycles
  task automatic t_prescale;
    logic [9:0] dv [3] = '{10'h001, 10'h002, 10'h3ff};
    int         n;
    int         hi;
    int         lo;
    reg_write(`SCS_ADDR_SYSCFG, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      reg_write(`SCS_ADDR_LOOPCFG, 16'h0400 | 16'(dv[i]));
      reg_check(`SCS_ADDR_LOOPCFG, 16'h0400 | 16'(dv[i]));
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      cmp_val(16'(hi + lo), 16'((dv[i] + 1) * 2));
      cmp_val(16'(hi), 16'(((dv[i] + 2) >> 1) * 2));
    end
  endtask

  task automatic t_flash;
    // Falling order leaves one state in force, so a dropped zero write is told from a reset
    for (int w = 4; w >= 1; w--) begin
      reg_write(`SCS_ADDR_FLASHWS, 16'(w));
      repeat (2) @(negedge clk_sys);
      cmp_val(16'(flash_wait_states), 16'(w));
      access(1'b0, w + 1);
      access(1'b1, 1);
    end
    reg_write(`SCS_ADDR_FLASHWS, 16'h0000);
    reg_check(`SCS_ADDR_FLASHWS, 16'h0001);
    reg_write(4'h5, 16'hffff);
    reg_check(4'h5, 16'h0000);
    reg_write(`SCS_ADDR_STATUS, 16'h0000);
    reg_check(`SCS_ADDR_STATUS, 16'h0001);
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ********************************************************************
  // Sequence and watchdog
  // ********************************************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_prescale();
    t_flash();
    conclude();
  end

  // Whole run needs about 4400 cycles; the 40000-cycle limit is about nine times that
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire

// >>> test/scs_src_model.sv
// Behavioural oscillators and clock inputs at the far side of the selector
`timescale 1ns/100ps
`default_nettype none

module scs_src_model (
  // Clock
  input  wire logic         clk_sys,
  // Sampled source levels
  output scs_pkg::scs_src_t src
);
  // ********************************************************************
  // Source patterns
  // ********************************************************************
  // Each source differs from every other in rate or duty, so a swapped source is seen
  logic [7:0] cnt_r = 8'h00;

  always @(posedge clk_sys) begin
    cnt_r <= cnt_r + 8'h01;
  end

  assign src = {cnt_r[1:0] == 2'h0, cnt_r[0], cnt_r[1], cnt_r[2] ^ cnt_r[0], cnt_r[3]};
endmodule
`default_nettype wire
